// [rtl/wwdt_pkg.sv]
/*
  Shared constants and types of the window watchdog: register offsets,
  control field positions, reset values, timing and the state encoding.
  Assumes a 100 MHz system clock and an 8-bit byte address on the register port.
*/
package wwdt_pkg;

  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_SRV = 8'h08;
  localparam logic [7:0] OFS_MIRROR = 8'h0c;
  localparam logic [7:0] OFS_LOWER = 8'h10;
  localparam logic [7:0] OFS_UPPER = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_CAUSE = 8'h20;

  localparam int CTRL_ENB = 0;
  localparam int CTRL_PRE = 1;
  localparam int CTRL_DSP = 4;
  localparam int CTRL_SPW_LO = 8;
  localparam int CTRL_SPW_HI = 15;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_ff13;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BOUND_RST = 32'h0000_0000;
  localparam logic [31:0] MAGIC_WORD = 32'habad_cafe;

  // Arbitrary identification values
  localparam logic [15:0] ID_NUMBER = 16'h00a5;
  localparam logic [7:0] ID_TYPE = 8'hc0;
  localparam logic [7:0] ID_REV = 8'h01;

  localparam int SYS_CLK_HZ = 100000000;
  localparam int WDT_CLK_HZ = 32000;
  localparam int TICK_DIV = SYS_CLK_HZ / WDT_CLK_HZ;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ALARM = 2'b01,
    ST_RSTREQ = 2'b10
  } wwdt_state_t;

  function automatic logic wwdt_in_window(
    input logic [31:0] cnt,
    input logic [31:0] lo,
    input logic [31:0] hi);
    wwdt_in_window = (cnt >= lo) && (cnt <= hi);
  endfunction

endpackage

// [rtl/wwdt_tick.sv]
/*
  Divider producing the watchdog counting tick from the system clock.
  Assumes the system clock rate given in the package.
*/
`timescale 1ns/1ps
module wwdt_tick import wwdt_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  output logic tick_ff
);

  localparam logic [11:0] DIV_LAST = 12'(TICK_DIV - 1);

  logic [11:0] div_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 12'h000;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff <= 12'h000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 12'h001;
      tick_ff <= 1'b0;
    end
  end

endmodule // wwdt_tick

// [rtl/wwdt_pulse.sv]
/*
  Service indication stretcher: holds its output for width+1 ticks.
  Assumes start comes aligned with a tick pulse.
*/
`timescale 1ns/1ps
module wwdt_pulse import wwdt_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] width,
  output logic pulse_ff
);

  logic [8:0] left_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      left_ff <= 9'h000;
      pulse_ff <= 1'b0;
    end else if (start) begin
      left_ff <= {1'b0, width};
      pulse_ff <= 1'b1;
    end else if (tick && pulse_ff) begin
      if (left_ff == 9'h000) begin
        pulse_ff <= 1'b0;
      end else begin
        left_ff <= left_ff - 9'h001;
      end
    end
  end

endmodule // wwdt_pulse

// [rtl/wwdt_top.sv]
/*
  Window watchdog top: register port, tick-domain shadow of the
  configuration, counter, window check, alarm and reset request logic.
  Assumes a single-cycle register master and a separate power-on reset
  that the system reset does not reach.
*/
`timescale 1ns/1ps
module wwdt_top import wwdt_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic por_nrst,
  input wire logic dbg_halt,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  output logic service_ff,
  output logic service_pin_ff,
  output logic alarm_ff,
  output logic rst_req_ff
);

  logic tick;
  logic svc_pulse;

  logic [31:0] control_reg_ff;
  logic [31:0] window_lower_bound_ff;
  logic [31:0] window_upper_bound_ff;
  logic [31:0] counter_mirror_ff;
  logic reset_cause_flag_ff;

  logic [31:0] ctrl_sh_ff;
  logic [31:0] lower_sh_ff;
  logic [31:0] upper_sh_ff;

  logic srv_pend_ff;
  logic [31:0] srv_word_ff;

  logic clr_pend_ff;

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  wwdt_state_t state_ff;
  wwdt_state_t nxt_state;

  logic wr_ctrl;
  logic wr_srv;
  logic wr_lower;
  logic wr_upper;
  logic wr_clear;
  logic wr_cause;

  logic enabled;
  logic running;
  logic svc_eval;
  logic svc_good;
  logic svc_bad;
  logic overflow;
  logic alarm_evt;
  logic rst_evt;
  logic svc_start;

  // One decoder for every write strobe
  function automatic logic addr_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] ofs);
    addr_hit = strobe && (addr == ofs);
  endfunction

  assign wr_ctrl = addr_hit(reg_wr, reg_addr, OFS_CTRL);
  assign wr_srv = addr_hit(reg_wr, reg_addr, OFS_SRV);
  assign wr_lower = addr_hit(reg_wr, reg_addr, OFS_LOWER);
  assign wr_upper = addr_hit(reg_wr, reg_addr, OFS_UPPER);
  assign wr_clear = addr_hit(reg_wr, reg_addr, OFS_CLEAR) && reg_wdata[0];
  assign wr_cause = addr_hit(reg_wr, reg_addr, OFS_CAUSE) && reg_wdata[0];

  wwdt_tick u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick_ff(tick)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      control_reg_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      control_reg_ff <= reg_wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      window_lower_bound_ff <= BOUND_RST;
    end else if (wr_lower) begin
      window_lower_bound_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      window_upper_bound_ff <= BOUND_RST;
    end else if (wr_upper) begin
      window_upper_bound_ff <= reg_wdata;
    end
  end

  // configuration takes effect at tick
  // Copies move only on tick, so a decision never sees a half-written word
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_sh_ff <= CTRL_RST;
    end else if (tick) begin
      ctrl_sh_ff <= control_reg_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lower_sh_ff <= BOUND_RST;
    end else if (tick) begin
      lower_sh_ff <= window_lower_bound_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      upper_sh_ff <= BOUND_RST;
    end else if (tick) begin
      upper_sh_ff <= window_upper_bound_ff;
    end
  end

  // service word held until next tick
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      srv_pend_ff <= 1'b0;
      srv_word_ff <= 32'h0000_0000;
    end else if (wr_srv) begin
      srv_pend_ff <= 1'b1;
      srv_word_ff <= reg_wdata;
    end else if (tick) begin
      srv_pend_ff <= 1'b0;
    end
  end

  // Clear request waits for tick; new write wins over consumption
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clr_pend_ff <= 1'b0;
    end else if (wr_clear) begin
      clr_pend_ff <= 1'b1;
    end else if (tick) begin
      clr_pend_ff <= 1'b0;
    end
  end

  // disabled means no count, no request
  assign enabled = ctrl_sh_ff[CTRL_ENB] && (state_ff != ST_RSTREQ);

  assign running = enabled && !(dbg_halt && !ctrl_sh_ff[CTRL_DSP]);

  assign svc_eval = tick && srv_pend_ff && enabled;

  assign svc_good = svc_eval && (srv_word_ff == MAGIC_WORD) &&
                    wwdt_in_window(cnt_ff, lower_sh_ff, upper_sh_ff);

  assign svc_bad = svc_eval && !svc_good;

  assign overflow = tick && running && !svc_eval && (cnt_ff > upper_sh_ff);

  assign alarm_evt = overflow && ctrl_sh_ff[CTRL_PRE] && (state_ff == ST_RUN);

  assign rst_evt = svc_bad || (overflow && !alarm_evt);

  assign svc_start = svc_good;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (svc_good || alarm_evt) begin
      nxt_cnt = 32'h0000_0000;
    end else if (tick && running && !rst_evt) begin
      nxt_cnt = cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (rst_evt) begin
          nxt_state = ST_RSTREQ;
        end else if (alarm_evt) begin
          nxt_state = ST_ALARM;
        end
      end
      ST_ALARM: begin
        if (rst_evt) begin
          nxt_state = ST_RSTREQ;
        end else if (tick && clr_pend_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RSTREQ: begin
        nxt_state = ST_RSTREQ;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      counter_mirror_ff <= 32'h0000_0000;
    end else begin
      counter_mirror_ff <= cnt_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= alarm_evt;
    end
  end

  // Held until the system reset takes it away
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_req_ff <= 1'b0;
    end else begin
      rst_req_ff <= (nxt_state == ST_RSTREQ);
    end
  end

  always_ff @(posedge sys_clk or negedge por_nrst) begin
    if (!por_nrst) begin
      reset_cause_flag_ff <= 1'b0;
    end else if (rst_req_ff) begin
      reset_cause_flag_ff <= 1'b1;
    end else if (wr_cause) begin
      reset_cause_flag_ff <= 1'b0;
    end
  end

  wwdt_pulse u_pulse (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(tick),
    .start(svc_start),
    .width(ctrl_sh_ff[CTRL_SPW_HI:CTRL_SPW_LO]),
    .pulse_ff(svc_pulse)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      service_ff <= 1'b0;
      service_pin_ff <= 1'b0;
    end else begin
      service_ff <= svc_pulse;
      service_pin_ff <= svc_pulse;
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_ID: begin
          reg_rdata_ff <= {ID_NUMBER, ID_TYPE, ID_REV};
        end
        OFS_CTRL: begin
          reg_rdata_ff <= control_reg_ff;
        end
        OFS_MIRROR: begin
          reg_rdata_ff <= counter_mirror_ff;
        end
        OFS_LOWER: begin
          reg_rdata_ff <= window_lower_bound_ff;
        end
        OFS_UPPER: begin
          reg_rdata_ff <= window_upper_bound_ff;
        end
        OFS_STATUS: begin
          reg_rdata_ff <= {31'h0000_0000, state_ff == ST_ALARM};
        end
        OFS_CAUSE: begin
          reg_rdata_ff <= {31'h0000_0000, reset_cause_flag_ff};
        end
        default: begin
          reg_rdata_ff <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

endmodule // wwdt_top

// [verif/wwdt_chk.sv]
/* Port checker of wwdt_top.
   Bound from the bench top; one clock, nrst async active low. */
`timescale 1ns/1ps
module wwdt_chk import wwdt_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic por_nrst,
  input wire logic dbg_halt,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic service_ff,
  input wire logic service_pin_ff,
  input wire logic alarm_ff,
  input wire logic rst_req_ff
);
  logic en_q_ff;
  logic alarmed_ff;
  logic [15:0] idle_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shadow of enable settles at the first tick after the write; the check waits past two ticks
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_q_ff <= 1'b0;
      idle_ff <= 16'h0000;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      en_q_ff <= reg_wdata[CTRL_ENB];
      idle_ff <= 16'h0000;
    end else if (idle_ff != 16'hffff) begin
      idle_ff <= idle_ff + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarmed_ff <= 1'b0;
    end else if (alarm_ff || (reg_wr && reg_addr == OFS_CLEAR)) begin
      alarmed_ff <= alarm_ff;
    end
  end
  sequence s_rd_id;
    reg_rd && reg_addr == OFS_ID;
  endsequence
  sequence s_req_hold;
    rst_req_ff [*8];
  endsequence
  AST_PIN_COPY: assert property (service_pin_ff == service_ff)
    else $error("service pin differs from service output");
  AST_REQ_HELD: assert property ($rose(rst_req_ff) |-> s_req_hold)
    else $error("reset request dropped before system reset");
  AST_ALARM_PULSE: assert property (alarm_ff |=> !alarm_ff)
    else $error("alarm longer than one cycle");
  AST_ALARM_NO_REQ: assert property (alarm_ff |-> !rst_req_ff)
    else $error("alarm and reset request together");
  AST_ID_READ: assert property (s_rd_id |=> reg_rdata_ff == {ID_NUMBER, ID_TYPE, ID_REV})
    else $error("identification word wrong");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_ff == 32'h0000_0000)
    else $error("read data outside its cycle");
  AST_STATUS_SET: assert property (reg_rd && reg_addr == OFS_STATUS && alarmed_ff |=> reg_rdata_ff[0])
    else $error("alarm status not shown");
  AST_QUIET: assert property (!en_q_ff && idle_ff > 16'h1900 |-> !alarm_ff && !$rose(rst_req_ff))
    else $error("disabled watchdog raised an event");
  AST_SVC_LEN: assert property ($rose(service_ff) |-> service_ff [*8] ##1 !rst_req_ff)
    else $error("service pulse too short");
endmodule // wwdt_chk

// [verif/wwdt_scu_model.sv]
/* Reset and clock control unit model.
   Turns a reset request into a short system reset; counts unmasked alarms. */
`timescale 1ns/1ps
module wwdt_scu_model (
  input wire logic sys_clk,
  input wire logic rst_req,
  input wire logic alarm,
  input wire logic irq_mask,
  output logic sys_nrst_ff,
  output int irq_cnt
);
  int hold = 0;
  int lag = 0;
  initial sys_nrst_ff = 1'b1;
  initial irq_cnt = 0;
  // request becomes reset
  // Answers ten cycles late, so the request must stand meanwhile
  always @(posedge sys_clk) begin
    if (hold > 0) begin
      hold <= hold - 1;
      sys_nrst_ff <= (hold == 1);
    end else if (rst_req && lag == 9) begin
      lag <= 0;
      hold <= 3;
      sys_nrst_ff <= 1'b0;
    end else if (rst_req) begin
      lag <= lag + 1;
    end else begin
      lag <= 0;
    end
  end
  always @(posedge sys_clk) begin
    if (alarm && !irq_mask) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
endmodule // wwdt_scu_model

// [verif/tb_wwdt.sv]
/* Bench of wwdt_top with the reset unit model.
   Assumes a tick every TICK_DIV system cycles. */
`timescale 1ns/1ps
module tb_wwdt import wwdt_pkg::*;;
  localparam int T = TICK_DIV;
  logic sys_clk = 1'b0;
  logic tb_nrst = 1'b0;
  logic por_nrst = 1'b0;
  logic dbg_halt = 1'b0;
  logic irq_mask = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff, v, w;
  logic service_ff, service_pin_ff, alarm_ff, rst_req_ff, scu_nrst;
  logic [31:0] rnd = 32'h0000_001b;
  int irq_cnt, n;
  int mismatches = 0;
  int tests_run = 0;
  wire nrst = tb_nrst & scu_nrst;
  // module clock runs from the start
  always #5 sys_clk = ~sys_clk;
  wwdt_top u_wwdt_top (.sys_clk, .nrst, .por_nrst, .dbg_halt, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .service_ff, .service_pin_ff, .alarm_ff, .rst_req_ff);
  wwdt_scu_model u_wwdt_scu_model (.sys_clk, .rst_req(rst_req_ff), .alarm(alarm_ff), .irq_mask,
    .sys_nrst_ff(scu_nrst), .irq_cnt);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Two mirror reads exactly one tick apart
  task automatic span();
    rd(OFS_MIRROR, v);
    repeat (T - 2) @(posedge sys_clk);
    rd(OFS_MIRROR, w);
  endtask
  task automatic wait_on(input int sel, input int lim);
    for (n = 0; n < lim; n++) begin
      if ((sel == 0 && rst_req_ff) || (sel == 1 && service_ff) || (sel == 2 && alarm_ff)) break;
      @(posedge sys_clk);
      #1;
    end
  endtask
  // bounds first, then mode and enable
  task automatic arm(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] c);
    wr(OFS_LOWER, lo);
    wr(OFS_UPPER, hi);
    wr(OFS_CTRL, c);
    repeat (T + 10) @(posedge sys_clk);
  endtask
  task automatic boom(input int lim);
    wait_on(0, lim);
    chk(rst_req_ff, 1'b1);
    repeat (16) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(31 * T * 10);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    tb_nrst <= 1'b1;
    por_nrst <= 1'b1;
    rchk(OFS_CTRL, CTRL_RST);
    rchk(OFS_MIRROR, 32'h0000_0000);
    rchk(OFS_CAUSE, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    rchk(OFS_ID, {ID_NUMBER, ID_TYPE, ID_REV});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(OFS_CTRL, rnd & ~32'h1);
      rchk(OFS_CTRL, rnd & ~32'h1 & CTRL_WMASK);
    end
    wr(OFS_SRV, MAGIC_WORD);
    $display("Register test done");
    arm(32'h0, 32'h64, 32'h0000_0111);
    wr(OFS_SRV, MAGIC_WORD);
    wait_on(1, 2 * T);
    chk(service_ff, 1'b1);
    for (n = 0; service_ff && n < 4 * T; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(n > T && n <= 2 * T + 2, 1'b1);
    span();
    chk(v <= 3, 1'b1);
    chk(w, v + 1);
    wr(OFS_CTRL, 32'h0000_0101);
    dbg_halt <= 1'b1;
    repeat (2 * T) @(posedge sys_clk);
    span();
    chk(w, v);
    wr(OFS_CTRL, 32'h0000_0100);
    dbg_halt <= 1'b0;
    repeat (2 * T) @(posedge sys_clk);
    span();
    chk(w, v);
    $display("Service test done");
    wr(OFS_UPPER, 32'h0);
    wr(OFS_CTRL, 32'h0000_0011);
    boom(4 * T);
    rchk(OFS_CAUSE, 32'h0000_0001);
    rchk(OFS_CTRL, CTRL_RST);
    wr(OFS_CAUSE, 32'h1);
    rchk(OFS_CAUSE, 32'h0000_0000);
    arm(32'h0, 32'h32, 32'h0000_0011);
    rnd = lfsr(rnd);
    wr(OFS_SRV, rnd | 32'h1);
    boom(3 * T);
    rchk(OFS_UPPER, BOUND_RST);
    arm(32'h14, 32'h32, 32'h0000_0011);
    wr(OFS_SRV, MAGIC_WORD);
    boom(3 * T);
    $display("Bad service test done");
    arm(32'h0, 32'h0, 32'h0000_0013);
    wait_on(2, 4 * T);
    chk(alarm_ff, 1'b1);
    chk(rst_req_ff, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk(irq_cnt, 1);
    rchk(OFS_STATUS, 32'h0000_0001);
    irq_mask <= 1'b1;
    // clear first, then service in window
    wr(OFS_CLEAR, 32'h1);
    wr(OFS_SRV, MAGIC_WORD);
    wait_on(1, 2 * T);
    chk(service_ff, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0000);
    wait_on(2, 3 * T);
    chk(alarm_ff, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(irq_cnt, 1);
    boom(3 * T);
    $display("Pre-warning test done");
    give_verdict();
  end
endmodule // tb_wwdt
bind wwdt_top wwdt_chk u_wwdt_chk (.sys_clk, .nrst, .por_nrst, .dbg_halt, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_ff, .service_ff, .service_pin_ff, .alarm_ff, .rst_req_ff);
